// ---- leh_axis_model.sv ----
// linear encoder and proximity dog model for the home reference bench
`timescale 1ns/1ps
module leh_axis_model #(
	parameter int POS_W = 32
) (
	input wire logic ref_clk, // bench clock
	output logic enc_step, // count pulse pin
	output logic enc_dir, // direction pin
	output logic enc_ref_mark, // reference mark pin
	output logic dog_sense, // proximity dog pin
	output logic [POS_W-1:0] abs_pos, // absolute position word
	output logic abs_load // word strobe
);
	initial begin
		{enc_step, enc_dir, enc_ref_mark, dog_sense, abs_load} = '0;
		abs_pos = '0;
	end
	// two cycles high and two low so the pin synchroniser sees both edges
	task automatic step(input logic up);
		@(posedge ref_clk);
		enc_dir <= up;
		enc_step <= 1'b1;
		repeat (2) @(posedge ref_clk);
		enc_step <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask
	// one mark only, placed before the dog is met
	task automatic set_mark(input logic v);
		@(posedge ref_clk);
		enc_ref_mark <= v;
	endtask
	task automatic set_dog(input logic v);
		@(posedge ref_clk);
		dog_sense <= v;
	endtask
	// word is meaningless outside its strobe, so it shows garbage there
	task automatic load(input logic [POS_W-1:0] v);
		@(posedge ref_clk);
		abs_pos <= v;
		abs_load <= 1'b1;
		@(posedge ref_clk);
		abs_pos <= ~v;
		abs_load <= 1'b0;
	endtask
endmodule // leh_axis_model

// ---- leh_cfg.svh ----
// offsets, field positions, reset values and timing counts of the home reference block
`ifndef LEH_CFG_SVH
`define LEH_CFG_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define LEH_OFS_CTRL 8'h00
`define LEH_OFS_SHIFT 8'h04
`define LEH_OFS_STAT 8'h08
`define LEH_OFS_IRQ_STAT 8'h0C
`define LEH_OFS_IRQ_MASK 8'h10
`define LEH_OFS_POS 8'h14
`define LEH_OFS_HOME 8'h18
// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define LEH_CTRL_START 0
`define LEH_CTRL_ABS 1
`define LEH_CTRL_MULTI 2
`define LEH_CTRL_USE_Z 3
`define LEH_CTRL_NO_MARK 4
`define LEH_CTRL_DIG_LO 8
`define LEH_CTRL_DIG_HI 10
`define LEH_CTRL_RST 32'h0000_0308
// ---------------------------------------------------------------
// interrupt status bits
// ---------------------------------------------------------------
`define LEH_IRQ_DONE 0
`define LEH_IRQ_ALARM 1
`define LEH_IRQ_REFUSE 2
`define LEH_IRQ_MARK 3
`define LEH_IRQ_W 4
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define LEH_SYNC_STAGES 2
`endif

// ---- leh_home_ref.sv ----
// home reference, zero marker and homing alarm logic for a linear encoder axis
// Contract
// - absolute encoder: reference points every interval from absolute position zero.
// - incremental encoder: reference points every interval from the traversed mark.
// - interval digit 0..6 gives 8192,131072,262144,1048576,4194304,16777216,67108864.
// - after dog rear end, nearest reference point plus shift is home.
// - incremental: mark not passed before dog detection raises unpassed alarm.
// - absolute encoder: zero marker output at each reference point.
// - incremental encoder: zero marker output while at the mark position.
// - encoder without mark permits only homing that ignores the zero marker.
`timescale 1ns/1ps
`include "leh_cfg.svh"
module leh_home_ref import leh_pkg::*; #(
	parameter int POS_W = 32
) (
	input wire logic ref_clk, // 25 MHz clock
	input wire logic nrst, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic enc_step, // encoder count pulse pin
	input wire logic enc_dir, // encoder direction pin, high = positive
	input wire logic enc_ref_mark, // encoder reference mark pin
	input wire logic dog_sense, // proximity dog pin, high on dog
	input wire logic [POS_W-1:0] abs_pos, // absolute position word
	input wire logic abs_load, // strobe: abs_pos valid
	output logic encoder_zero_marker_out, // zero marker output
	output logic zero_phase_unpassed_alarm, // homing alarm level
	output logic irq // interrupt, high active
);
	// ---------------------------------------------------------------
	// elaboration check
	// ---------------------------------------------------------------
	generate
		if (POS_W < 28 || POS_W > 32) begin : g_bad_w
			$error("POS_W must lie in 28..32");
		end
	endgenerate

	// power-of-two intervals make the modulo compare a mask
	function automatic logic [POS_W-1:0] interval_mask(input leh_digit_t d);
		logic [4:0] sh;
		sh = 5'h0;
		case (d)
			3'h0: sh = 5'h0D;
			3'h1: sh = 5'h11;
			3'h2: sh = 5'h12;
			3'h3: sh = 5'h14;
			3'h4: sh = 5'h16;
			3'h5: sh = 5'h18;
			3'h6: sh = 5'h1A;
			default: sh = 5'h14;
		endcase
		return POS_W'((33'h1 << sh) - 33'h1);
	endfunction

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic [3:0] prev_r;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
			prev_r <= 4'h0;
		end else begin
			sync1_r <= {dog_sense, enc_ref_mark, enc_dir, enc_step};
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end
	logic step_ev, dir_pos, mark_lvl, mark_rise, dog_rise, dog_fall;
	assign step_ev = sync2_r[0] & ~prev_r[0];
	assign dir_pos = sync2_r[1];
	assign mark_lvl = sync2_r[2];
	assign mark_rise = sync2_r[2] & ~prev_r[2];
	assign dog_rise = sync2_r[3] & ~prev_r[3];
	assign dog_fall = ~sync2_r[3] & prev_r[3];

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [31:0] ctrl_r, ctrl_nxt;
	logic [31:0] shift_r, shift_nxt;
	logic [`LEH_IRQ_W-1:0] ist_r, ist_nxt, imsk_r, imsk_nxt;
	logic [POS_W-1:0] pos_r, pos_nxt, home_r, home_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic ref_seen_r, ref_seen_nxt, marker_r, marker_nxt, alarm_r, alarm_nxt;
	leh_state_e st_r, st_nxt;

	logic wr_acc, rd_setup, rd_acc, mapped, abs_mode, start;
	logic [POS_W-1:0] imask, near_ref;
	logic [`LEH_IRQ_W-1:0] ev;
	assign abs_mode = ctrl_r[`LEH_CTRL_ABS];
	assign imask = interval_mask(ctrl_r[`LEH_CTRL_DIG_HI:`LEH_CTRL_DIG_LO]);
	// round to nearest multiple, ties go positive
	assign near_ref = (pos_r + (imask >> 1) + POS_W'(1)) & ~imask;
	assign mapped = paddr inside {`LEH_OFS_CTRL, `LEH_OFS_SHIFT, `LEH_OFS_STAT,
		`LEH_OFS_IRQ_STAT, `LEH_OFS_IRQ_MASK, `LEH_OFS_POS, `LEH_OFS_HOME};
	assign wr_acc = psel & penable & pwrite & mapped;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign start = wr_acc && paddr == `LEH_OFS_CTRL && pwdata[`LEH_CTRL_START];
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = prdata_r;
	assign encoder_zero_marker_out = marker_r;
	assign zero_phase_unpassed_alarm = alarm_r;
	assign irq = |(ist_r & imsk_r);

	always_comb begin
		ctrl_nxt = ctrl_r;
		shift_nxt = shift_r;
		imsk_nxt = imsk_r;
		pos_nxt = pos_r;
		home_nxt = home_r;
		ref_seen_nxt = ref_seen_r;
		alarm_nxt = alarm_r;
		st_nxt = st_r;
		ev = '0;
		prdata_nxt = prdata_r;
		// register writes
		if (wr_acc) begin
			case (paddr)
				`LEH_OFS_CTRL: ctrl_nxt = pwdata & ~32'h0000_0001;
				`LEH_OFS_SHIFT: shift_nxt = pwdata;
				`LEH_OFS_IRQ_MASK: imsk_nxt = pwdata[`LEH_IRQ_W-1:0];
				default: ;
			endcase
		end
		// position counter relative to the reference mark, or loaded from the absolute word
		if (step_ev) begin
			pos_nxt = dir_pos ? pos_r + POS_W'(1) : pos_r - POS_W'(1);
		end
		if (abs_mode && abs_load) begin
			pos_nxt = abs_pos;
		end
		// only the first mark anchors unless several marks are allowed
		if (!abs_mode && mark_rise && (ctrl_r[`LEH_CTRL_MULTI] || !ref_seen_r)) begin
			pos_nxt = '0;
			ref_seen_nxt = 1'b1;
		end
		// zero marker
		if (abs_mode) begin
			marker_nxt = step_ev && ((pos_nxt & imask) == '0);
		end else begin
			marker_nxt = mark_lvl & ref_seen_nxt;
		end
		// homing sequence
		case (st_r)
			LEH_IDLE, LEH_DONE, LEH_FAIL: begin
				if (start) begin
					if (ctrl_nxt[`LEH_CTRL_USE_Z] && ctrl_nxt[`LEH_CTRL_NO_MARK]) begin
						ev[`LEH_IRQ_REFUSE] = 1'b1;
						st_nxt = LEH_IDLE;
					end else begin
						// a mark seen before start still counts as traversed
						alarm_nxt = 1'b0;
						st_nxt = LEH_SEEK;
					end
				end
			end
			LEH_SEEK: begin
				if (dog_rise) begin
					if (!abs_mode && !ref_seen_r) begin
						alarm_nxt = 1'b1;
						ev[`LEH_IRQ_ALARM] = 1'b1;
						st_nxt = LEH_FAIL;
					end else begin
						st_nxt = LEH_DOG;
					end
				end
			end
			LEH_DOG: begin
				if (dog_fall) begin
					home_nxt = near_ref + POS_W'(shift_r);
					ev[`LEH_IRQ_DONE] = 1'b1;
					st_nxt = LEH_DONE;
				end
			end
			default: st_nxt = LEH_IDLE;
		endcase
		ev[`LEH_IRQ_MARK] = marker_nxt & ~marker_r;
		// read data captured in the setup phase
		if (rd_setup) begin
			case (paddr)
				`LEH_OFS_CTRL: prdata_nxt = ctrl_r;
				`LEH_OFS_SHIFT: prdata_nxt = shift_r;
				`LEH_OFS_STAT: prdata_nxt = {25'h0, alarm_r, ref_seen_r, marker_r,
					1'b0, 3'(st_r)};
				`LEH_OFS_IRQ_STAT: prdata_nxt = 32'(ist_r);
				`LEH_OFS_IRQ_MASK: prdata_nxt = 32'(imsk_r);
				`LEH_OFS_POS: prdata_nxt = 32'(pos_r);
				`LEH_OFS_HOME: prdata_nxt = 32'(home_r);
				default: prdata_nxt = 32'h0;
			endcase
		end
		// clear only what was reported; a new event wins over the clear
		ist_nxt = ist_r;
		if (rd_acc && paddr == `LEH_OFS_IRQ_STAT) begin
			ist_nxt = ist_r & ~prdata_r[`LEH_IRQ_W-1:0];
		end
		ist_nxt = ist_nxt | ev;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_r <= `LEH_CTRL_RST;
			shift_r <= 32'h0;
			ist_r <= '0;
			imsk_r <= '0;
			pos_r <= '0;
			home_r <= '0;
			prdata_r <= 32'h0;
			ref_seen_r <= 1'b0;
			marker_r <= 1'b0;
			alarm_r <= 1'b0;
			st_r <= LEH_IDLE;
		end else begin
			ctrl_r <= ctrl_nxt;
			shift_r <= shift_nxt;
			ist_r <= ist_nxt;
			imsk_r <= imsk_nxt;
			pos_r <= pos_nxt;
			home_r <= home_nxt;
			prdata_r <= prdata_nxt;
			ref_seen_r <= ref_seen_nxt;
			marker_r <= marker_nxt;
			alarm_r <= alarm_nxt;
			st_r <= st_nxt;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	chk_interval_dflt: assert property (
		ctrl_r[`LEH_CTRL_DIG_HI:`LEH_CTRL_DIG_LO] == 3'h3 |-> imask == POS_W'(32'h000F_FFFF))
		else $error("default interval is not 1048576");
	chk_abs_origin: assert property (
		abs_mode && abs_load |=> pos_r == $past(abs_pos))
		else $error("absolute zero not taken as origin");
	chk_mark_origin: assert property (
		!abs_mode && !ref_seen_r && mark_rise |=> pos_r == '0 && ref_seen_r)
		else $error("first mark did not zero position");
	chk_abs_marker: assert property (
		abs_mode && step_ev && !abs_load && dir_pos && ((pos_r + POS_W'(1)) & imask) == '0
		|=> encoder_zero_marker_out)
		else $error("no marker at reference point");
	chk_inc_marker: assert property (
		!abs_mode && !mark_lvl |=> !encoder_zero_marker_out)
		else $error("marker away from mark position");
	chk_unpassed_alarm: assert property (
		st_r == LEH_SEEK && dog_rise && !abs_mode && !ref_seen_r
		|=> zero_phase_unpassed_alarm && st_r == LEH_FAIL ##1 ist_r[`LEH_IRQ_ALARM])
		else $error("unpassed alarm missing");
	chk_home_value: assert property (
		st_r == LEH_DOG && dog_fall
		|=> home_r == $past(near_ref) + POS_W'($past(shift_r)) && st_r == LEH_DONE)
		else $error("wrong home position");
	// a start during seek or dog is ignored, not refused
	chk_zero_refuse: assert property (
		start && (st_r == LEH_IDLE || st_r == LEH_DONE || st_r == LEH_FAIL)
		&& pwdata[`LEH_CTRL_USE_Z] && pwdata[`LEH_CTRL_NO_MARK]
		|=> st_r == LEH_IDLE ##1 ist_r[`LEH_IRQ_REFUSE])
		else $error("marker homing not refused");
	chk_alarm_clear: assert property (
		start && (st_r == LEH_IDLE || st_r == LEH_DONE || st_r == LEH_FAIL)
		&& !(pwdata[`LEH_CTRL_USE_Z] && pwdata[`LEH_CTRL_NO_MARK])
		|=> !zero_phase_unpassed_alarm && st_r == LEH_SEEK)
		else $error("accepted start did not clear alarm");
	chk_abs_no_marker: assert property (
		abs_mode && !step_ev |=> !encoder_zero_marker_out)
		else $error("marker without a landing step");
	chk_dog_seek: assert property (
		st_r == LEH_SEEK && dog_rise && (abs_mode || ref_seen_r) |=> st_r == LEH_DOG)
		else $error("dog front end not taken");
	chk_irq_clear: assert property (
		rd_acc && paddr == `LEH_OFS_IRQ_STAT && ev == '0
		|=> (ist_r & $past(prdata_r[`LEH_IRQ_W-1:0])) == '0)
		else $error("reported status bits not cleared");
	chk_pos_count: assert property (
		step_ev && dir_pos && !abs_load && !mark_rise |=> pos_r == $past(pos_r) + POS_W'(1))
		else $error("position count lost");

	// ---------------------------------------------------------------
	// scenario covers
	// ---------------------------------------------------------------
	cov_home_done: cover property (st_r == LEH_DOG ##1 st_r == LEH_DONE);
	cov_alarm: cover property ($rose(zero_phase_unpassed_alarm));
	cov_irq_clear: cover property (irq ##1 rd_acc && paddr == `LEH_OFS_IRQ_STAT ##1 !irq);
	cov_refuse: cover property ($rose(ist_r[`LEH_IRQ_REFUSE]));
	cov_abs_marker: cover property (abs_mode && $rose(encoder_zero_marker_out));
endmodule // leh_home_ref

// ---- leh_pkg.sv ----
// types of the home reference block
package leh_pkg;
	typedef enum {LEH_IDLE, LEH_SEEK, LEH_DOG, LEH_DONE, LEH_FAIL} leh_state_e;
	typedef logic [2:0] leh_digit_t;
endpackage

// ---- linear_encoder_home_reference_tb.sv ----
// self-checking bench of the home reference block
`timescale 1ns/1ps
`include "leh_cfg.svh"
module linear_encoder_home_reference_tb;
	logic ref_clk, nrst, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, abs_pos, sh, hm, r;
	logic pready, pslverr, enc_step, enc_dir, enc_ref_mark, dog_sense, abs_load;
	logic marker, alarm, irq;
	int num_errors = 0, num_checks = 0, seed = 46, mk_cnt = 0, n;
	logic [32:0] exp_q[$];
	logic [31:0] ivs[7] = '{32'h2000, 32'h20000, 32'h40000, 32'h100000, 32'h400000,
		32'h1000000, 32'h4000000};
	always #20 ref_clk = ~ref_clk;
	leh_home_ref dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .enc_step(enc_step), .enc_dir(enc_dir),
		.enc_ref_mark(enc_ref_mark), .dog_sense(dog_sense), .abs_pos(abs_pos),
		.abs_load(abs_load), .encoder_zero_marker_out(marker),
		.zero_phase_unpassed_alarm(alarm), .irq(irq));
	leh_axis_model m (.ref_clk(ref_clk), .enc_step(enc_step), .enc_dir(enc_dir),
		.enc_ref_mark(enc_ref_mark), .dog_sense(dog_sense), .abs_pos(abs_pos),
		.abs_load(abs_load));
	task automatic cmp_rd(input logic [32:0] ex, input logic [32:0] got);
		num_checks++;
		if (got !== ex) begin
			num_errors++;
			$display("unexpected read: expected %h seen %h", ex, got);
		end
	endtask
	task automatic cmp_pin(input string nm, input logic ex, input logic got);
		num_checks++;
		if (got !== ex) begin
			num_errors++;
			$display("unexpected %s: expected %b seen %b", nm, ex, got);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] ex);
		if (!wr)
			exp_q.push_back(ex);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic homing(input logic [31:0] c);
		apb(1'b1, `LEH_OFS_CTRL, c, 33'h0);
		m.set_dog(1'b1);
		repeat (6) @(posedge ref_clk);
		m.set_dog(1'b0);
		repeat (6) @(posedge ref_clk);
		#1;
	endtask
	// read notes are matched in issue order against what the slave returns
	always @(posedge ref_clk)
		if (psel && penable && pready && !pwrite)
			cmp_rd(exp_q.pop_front(), {pslverr, prdata});
	always @(posedge marker) mk_cnt++;
	initial begin
		ref_clk = 1'b0;
		nrst = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		apb(1'b0, `LEH_OFS_CTRL, 32'h0, {1'b0, `LEH_CTRL_RST});
		apb(1'b0, `LEH_OFS_STAT, 32'h0, 33'h0);
		apb(1'b0, 8'h1C, 32'h0, {1'b1, 32'h0});
		$display("test reset done");
		// no mark passed since reset, so homing must fail
		apb(1'b1, `LEH_OFS_IRQ_MASK, 32'hF, 33'h0);
		homing(32'h309);
		cmp_pin("alarm", 1'b1, alarm);
		cmp_pin("irq", 1'b1, irq);
		apb(1'b0, `LEH_OFS_STAT, 32'h0, 33'h44);
		apb(1'b0, `LEH_OFS_IRQ_STAT, 32'h0, 33'h2);
		#1 cmp_pin("irq", 1'b0, irq);
		apb(1'b1, `LEH_OFS_IRQ_MASK, 32'h0, 33'h0);
		apb(1'b1, `LEH_OFS_CTRL, 32'h319, 33'h0);
		#1 cmp_pin("irq", 1'b0, irq);
		apb(1'b0, `LEH_OFS_STAT, 32'h0, 33'h40);
		apb(1'b0, `LEH_OFS_IRQ_STAT, 32'h0, 33'h4);
		$display("test alarm and refusal done");
		apb(1'b1, `LEH_OFS_CTRL, 32'h8, 33'h0);
		m.set_mark(1'b1);
		repeat (4) @(posedge ref_clk);
		#1 cmp_pin("marker", 1'b1, marker);
		m.set_mark(1'b0);
		repeat (4) @(posedge ref_clk);
		#1 cmp_pin("marker", 1'b0, marker);
		repeat (5) m.step(1'b1);
		apb(1'b0, `LEH_OFS_POS, 32'h0, 33'h5);
		sh = $random(seed) & 32'hFFFF;
		apb(1'b1, `LEH_OFS_SHIFT, sh, 33'h0);
		homing(32'h9);
		cmp_pin("alarm", 1'b0, alarm);
		apb(1'b0, `LEH_OFS_STAT, 32'h0, 33'h23);
		apb(1'b0, `LEH_OFS_HOME, 32'h0, {1'b0, sh});
		apb(1'b0, `LEH_OFS_IRQ_STAT, 32'h0, 33'h9);
		$display("test incremental home done");
		// up onto a multiple, up off it, down onto it again: two pulses
		for (int d = 0; d < 7; d++) begin
			apb(1'b1, `LEH_OFS_CTRL, {21'h0, 3'(d), 8'h02}, 33'h0);
			n = mk_cnt;
			m.load(ivs[d] - 32'h1);
			m.step(1'b1);
			m.step(1'b1);
			m.step(1'b0);
			repeat (4) @(posedge ref_clk);
			#1 cmp_pin("marker count", 1'b1, (mk_cnt - n) == 2);
		end
		apb(1'b0, `LEH_OFS_IRQ_STAT, 32'h0, 33'h8);
		$display("test interval decode done");
		for (int k = 0; k < 2; k++) begin
			r = k ? 32'h1000 : $unsigned($random(seed)) % 32'h2000;
			hm = ((r >= 32'h1000) ? 32'h8000 : 32'h6000) + sh;
			m.load(32'h6000 + r);
			homing(32'h3);
			apb(1'b0, `LEH_OFS_HOME, 32'h0, {1'b0, hm});
			apb(1'b0, `LEH_OFS_IRQ_STAT, 32'h0, 33'h1);
		end
		$display("test absolute home done");
		wrap_up;
	end
	// whole run is a few hundred cycles; this bound only catches a hang
	initial begin
		#(40 * 20000);
		num_errors++;
		wrap_up;
	end
endmodule // linear_encoder_home_reference_tb
